// file: accel_operating_mode_control_tb.sv
// Self-checking bench of the operating mode controller.
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; \
	$display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module accel_operating_mode_control_tb;
	localparam int unsigned BL = 20; // Shortened boot and hold counts
	logic sys_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic strap, wake_req, mot_low, trig_req, fsel_req, wake_cs, motion, trig, fsel;
	logic active, hib_en, aslp_en, activity, w_hpm, s_hpm, w_flex, s_flex;
	logic [15:0] aslp_cnt;
	logic [3:0] w_odr, s_odr, w_dec, s_dec;
	logic [7:0] w_idle, s_idle;
	logic [6:0] mode;
	logic bus, analog, hp, rdef, rsub, aset, bdone, mdone;
	logic [31:0] rng;
	int err_total = 0;
	int checks = 0;
	int on, dn;
	always #10 sys_clk_i = ~sys_clk_i;
	////////////////////////////////////////////////////////////////////////
	aomc_host_model #(.HOLD_CYC(BL)) u_host (.sys_clk_i(sys_clk_i), .strap_i(strap),
		.wake_req_i(wake_req), .mot_low_req_i(mot_low), .trig_req_i(trig_req),
		.fsel_req_i(fsel_req), .wake_cs_o(wake_cs), .motion_o(motion), .trig_o(trig),
		.fsel_o(fsel));
	aomc_mode_ctrl #(.BOOT_LOW_CYC(BL), .BOOT_HIGH_CYC(BL), .MOT_HOLD_CYC(BL)) u_dut (
		.sys_clk_i(sys_clk_i), .rst_i(rst_i), .boot_strap_select_i(strap), .wake_cs_i(wake_cs),
		.motion_detect_pin_i(motion), .external_trigger_input_i(trig), .active_i(active),
		.hibernate_en_i(hib_en), .second_pin_function_select_i(fsel), .auto_sleep_en_i(aslp_en),
		.auto_sleep_count_i(aslp_cnt), .activity_i(activity), .wake_hpm_i(w_hpm),
		.wake_odr_i(w_odr), .wake_flex_en_i(w_flex), .wake_idle_i(w_idle), .wake_dec_i(w_dec),
		.sleep_hpm_i(s_hpm), .sleep_odr_i(s_odr), .sleep_flex_en_i(s_flex),
		.sleep_idle_i(s_idle), .sleep_dec_i(s_dec), .mode_o(mode), .bus_avail_o(bus),
		.analog_on_o(analog), .high_perf_o(hp), .regs_default_o(rdef),
		.regs_subset_rst_o(rsub), .active_set_o(aset), .boot_done_o(bdone), .meas_done_o(mdone));
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] v;
		v = s ^ (s << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction : xs
	// Power window of one measurement, stretched by decimation when flexible
	function automatic int exp_on(input logic flex, input logic [3:0] dec);
		return flex ? int'(aomc_pkg::MEAS_CYC) * (int'(dec) + 1) : int'(aomc_pkg::MEAS_CYC);
	endfunction : exp_on
	task automatic wait_mode(input logic [6:0] m, input int lim);
		for (int n = 0; n < lim && mode !== m; n++) @(negedge sys_clk_i);
		`CHK(mode, m)
	endtask : wait_mode
	task automatic idle(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask : idle
	// Trigger pulse, then count power cycles and completions in a fixed window
	task automatic trig_once(output int on_cyc, output int dn_cyc);
		on_cyc = 0;
		dn_cyc = 0;
		for (int n = 0; n < 700; n++) begin
			trig_req = (n < 8);
			@(negedge sys_clk_i);
			on_cyc += int'(analog);
			dn_cyc += int'(mdone);
		end
	endtask : trig_once
	task automatic conclude();
		$display("Checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : conclude
	////////////////////////////////////////////////////////////////////////
	// Main sequence: strap low tour, then strap high tour
	initial begin
		{strap, wake_req, mot_low, trig_req, fsel_req, active, hib_en, aslp_en, activity} = '0;
		{w_flex, s_flex, w_idle, s_idle, w_dec, s_dec, aslp_cnt} = '0;
		rng = xs(32'h18);
		{w_hpm, s_hpm} = rng[1:0];
		w_odr = {2'h0, rng[3:2]} + 4'h1;
		s_odr = {2'h0, rng[5:4]} + 4'h1;
		idle(10);
		rst_i = 1'b0;
		idle(40);
		`CHK(mode, 7'h01)
		`CHK(bus, 1'b0)
		`CHK(rdef, 1'b1)
		wake_req = 1'b1;
		idle(1);
		wake_req = 1'b0;
		wait_mode(7'h04, 200);
		`CHK(bus, 1'b1)
		`CHK(rdef, 1'b0)
		active = 1'b1;
		wait_mode(7'h08, 50);
		idle(600);
		`CHK(mode, 7'h08)
		`CHK(hp, w_hpm)
		aslp_cnt = {14'h0, rng[7:6]} + 16'h1;
		wait_mode(7'h10, 3000);
		`CHK(hp, s_hpm)
		activity = 1'b1;
		wait_mode(7'h08, 3000);
		{activity, active, aslp_cnt} = '0;
		wait_mode(7'h04, 1000);
		fsel_req = 1'b1;
		wait_mode(7'h20, 50);
		// Random gaps, zero gives back-to-back triggers
		for (int i = 0; i < 3; i++) begin
			rng = xs(rng);
			{w_flex, w_dec} = {rng[4], 1'b0, rng[7:5]};
			idle(int'(rng[11:8]));
			trig_once(on, dn);
			`CHK(on, exp_on(w_flex, w_dec))
			`CHK(dn, 1)
			`CHK(mode, 7'h20)
		end
		fsel_req = 1'b0;
		wait_mode(7'h04, 50);
		hib_en = 1'b1;
		wait_mode(7'h01, 50);
		hib_en = 1'b0;
		`CHK(bus, 1'b0)
		mot_low = 1'b1;
		idle(2);
		strap = 1'b1;
		idle(20);
		mot_low = 1'b0;
		wait_mode(7'h08, 300);
		`CHK(aset, 1'b1)
		fsel_req = 1'b1;
		aslp_cnt = 16'h0002;
		idle(600);
		`CHK(mode, 7'h08)
		aslp_en = 1'b1;
		wait_mode(7'h10, 3000);
		mot_low = 1'b1;
		wait_mode(7'h01, 300);
		idle(100);
		`CHK(mode, 7'h01)
		conclude();
	end
	// Watchdog well beyond the roughly 4000 cycles the tour needs
	initial begin
		idle(60000);
		err_total++;
		conclude();
	end
endmodule : accel_operating_mode_control_tb

// file: aomc_host_model.sv
// Host side model: wake toggle, pulled-up motion pin, trigger pin, select gating.
`timescale 1ns/1ps
module aomc_host_model #(
	parameter int unsigned HOLD_CYC = 20
) (
	// Clock
	input  wire logic sys_clk_i,
	// Requests from the bench
	input  wire logic strap_i,
	input  wire logic wake_req_i,
	input  wire logic mot_low_req_i,
	input  wire logic trig_req_i,
	input  wire logic fsel_req_i,
	// Pins towards the device
	output logic      wake_cs_o,
	output logic      motion_o,
	output logic      trig_o,
	output logic      fsel_o
);
	int unsigned hold_cnt;
	// Idle pin levels at time zero
	initial begin
		wake_cs_o = 1'b1;
		trig_o = 1'b0;
		hold_cnt = 0;
	end
	always @(negedge sys_clk_i) begin
		if (wake_req_i) begin
			wake_cs_o <= ~wake_cs_o;
		end
		hold_cnt <= mot_low_req_i ? HOLD_CYC + 4 : (hold_cnt != 0 ? hold_cnt - 1 : 0);
		trig_o <= trig_req_i;
	end
	// pull-up wins once the hold runs out
	assign motion_o = (hold_cnt == 0);
	// select kept zero with strap high
	assign fsel_o = fsel_req_i & ~strap_i;
endmodule : aomc_host_model

// file: aomc_meas_timer.sv
// Measurement pacing timer: idle spacing, decimation and per-cycle power window.
`timescale 1ns/1ps
module aomc_meas_timer (
	// Clock and reset
	input  wire logic                         sys_clk_i,
	input  wire logic                         rst_i,
	// Control
	input  wire logic                         run_i,
	input  wire logic                         single_i,
	input  wire logic [aomc_pkg::ODR_W-1:0]   odr_i,
	input  wire logic                         flex_en_i,
	input  wire logic [aomc_pkg::IDLE_W-1:0]  idle_i,
	input  wire logic [aomc_pkg::DEC_W-1:0]   dec_i,
	// Status
	output logic                              analog_on_o,
	output logic                              meas_done_o
);

	logic [aomc_pkg::MEAS_W-1:0] meas_reg;
	logic [aomc_pkg::IDLE_W+aomc_pkg::ODR_W-1:0] gap_reg;
	logic [aomc_pkg::DEC_W-1:0]  dec_reg;
	logic                        busy_reg;
	logic                        start_w;
	logic                        last_w;
	logic [aomc_pkg::IDLE_W+aomc_pkg::ODR_W-1:0] gap_load_w;

	// Flexible setting uses programmed idle, else ODR code sets spacing
	assign gap_load_w = flex_en_i ? {{aomc_pkg::ODR_W{1'b0}}, idle_i}
	                              : {{aomc_pkg::IDLE_W{1'b0}}, odr_i} << 4;
	assign start_w = !busy_reg && (single_i || (run_i && gap_reg == '0));
	assign last_w  = busy_reg && meas_reg == aomc_pkg::MEAS_W'(aomc_pkg::MEAS_CYC - 1);

	// Power only while a conversion runs; decimation repeats conversions
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || (!run_i && !single_i && !busy_reg)) begin
			meas_reg    <= '0;
			gap_reg     <= '0;
			dec_reg     <= '0;
			busy_reg    <= 1'b0;
			analog_on_o <= 1'b0;
			meas_done_o <= 1'b0;
		end else begin
			meas_done_o <= 1'b0;
			if (start_w) begin
				busy_reg    <= 1'b1;
				analog_on_o <= 1'b1;
				meas_reg    <= '0;
			end else if (last_w) begin
				meas_reg <= '0;
				if (flex_en_i && dec_reg != dec_i) begin
					dec_reg <= dec_reg + 1'b1;
				end else begin
					dec_reg     <= '0;
					busy_reg    <= 1'b0;
					analog_on_o <= 1'b0;
					meas_done_o <= 1'b1;
					gap_reg     <= gap_load_w;
				end
			end else if (busy_reg) begin
				meas_reg <= meas_reg + 1'b1;
			end else if (gap_reg != '0) begin
				gap_reg <= gap_reg - 1'b1;
			end
		end
	end

endmodule : aomc_meas_timer

// file: aomc_mode_ctrl.sv
// Operating mode controller of a three-axis accelerometer.
// Operation
// - Hibernate keeps wake detect only, bus off
// - Strap high: motion pin high starts boot
// - Strap high: bus usable after second boot wait
// - Standby: analog off, serial bus available
// - Active: analog power per measurement, bus on
// - Strap low: auto sleep when count nonzero
// - Strap high: auto sleep defaults disabled
// - Trigger rising edge starts one measurement
// - After triggered measurement return to wait
// - Trigger mode keeps serial bus answering
// - Active to Standby retains; reverse resets subset
// - Hibernate exit reloads defaults, entry discards all
// - Sleep and wake own rate and power settings
// - Flexible setting per sub-mode, idle and decimation
// - Strap low: hibernate bit in Standby hibernates
// - Strap high: motion pin low hold hibernates
// - Strap low: active bit toggles Standby and wake
`timescale 1ns/1ps
module aomc_mode_ctrl #(
	parameter int unsigned BOOT_LOW_CYC  = aomc_pkg::BOOT_WAIT_LOW_CYC,
	parameter int unsigned BOOT_HIGH_CYC = aomc_pkg::BOOT_WAIT_HIGH_CYC,
	parameter int unsigned MOT_HOLD_CYC  = aomc_pkg::MOT_LOW_HOLD_CYC
) (
	// Clock and reset
	input  wire logic                          sys_clk_i,
	input  wire logic                          rst_i,
	// Pins
	input  wire logic                          boot_strap_select_i,
	input  wire logic                          wake_cs_i,
	input  wire logic                          motion_detect_pin_i,
	input  wire logic                          external_trigger_input_i,
	// Configuration from register file
	input  wire logic                          active_i,
	input  wire logic                          hibernate_en_i,
	input  wire logic                          second_pin_function_select_i,
	input  wire logic                          auto_sleep_en_i,
	input  wire logic [aomc_pkg::ASLP_W-1:0]   auto_sleep_count_i,
	input  wire logic                          activity_i,
	input  wire logic                          wake_hpm_i,
	input  wire logic [aomc_pkg::ODR_W-1:0]    wake_odr_i,
	input  wire logic                          wake_flex_en_i,
	input  wire logic [aomc_pkg::IDLE_W-1:0]   wake_idle_i,
	input  wire logic [aomc_pkg::DEC_W-1:0]    wake_dec_i,
	input  wire logic                          sleep_hpm_i,
	input  wire logic [aomc_pkg::ODR_W-1:0]    sleep_odr_i,
	input  wire logic                          sleep_flex_en_i,
	input  wire logic [aomc_pkg::IDLE_W-1:0]   sleep_idle_i,
	input  wire logic [aomc_pkg::DEC_W-1:0]    sleep_dec_i,
	// Status and power controls
	output logic [6:0]                         mode_o,
	output logic                               bus_avail_o,
	output logic                               analog_on_o,
	output logic                               high_perf_o,
	output logic                               regs_default_o,
	output logic                               regs_subset_rst_o,
	output logic                               active_set_o,
	output logic                               boot_done_o,
	output logic                               meas_done_o
);

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: three stages, change counts when stages 2 and 3 agree

	logic [3:0] sync1_reg;
	logic [3:0] sync2_reg;
	logic [3:0] sync3_reg;
	logic [3:0] pin_reg;
	logic [3:0] pin_raw_w;

	assign pin_raw_w = {external_trigger_input_i, motion_detect_pin_i, wake_cs_i,
	                    boot_strap_select_i};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			// Stage one feeds stage two; idle reset avoids a false edge
			always_ff @(posedge sys_clk_i) begin
				if (rst_i) begin
					sync1_reg[gi] <= aomc_pkg::PIN_IDLE[gi];
					sync2_reg[gi] <= aomc_pkg::PIN_IDLE[gi];
					sync3_reg[gi] <= aomc_pkg::PIN_IDLE[gi];
					pin_reg[gi]   <= aomc_pkg::PIN_IDLE[gi];
				end else begin
					sync1_reg[gi] <= pin_raw_w[gi];
					sync2_reg[gi] <= sync1_reg[gi];
					sync3_reg[gi] <= sync2_reg[gi];
					if (sync2_reg[gi] == sync3_reg[gi]) begin
						pin_reg[gi] <= sync3_reg[gi];
					end
				end
			end
		end
	endgenerate

	logic strap_w, cs_w, mot_w, trig_w;
	assign strap_w = pin_reg[0];
	assign cs_w    = pin_reg[1];
	assign mot_w   = pin_reg[2];
	assign trig_w  = pin_reg[3];

	////////////////////////////////////////////////////////////////////////////
	// Edge history and strap capture

	logic cs_prev_reg;
	logic trig_prev_reg;
	logic strap_reg;
	logic cs_toggle_w;
	logic trig_rise_w;

	assign cs_toggle_w = cs_w != cs_prev_reg;
	assign trig_rise_w = trig_w && !trig_prev_reg;

	// Strap latched each boot so a mid-run change cannot alter mode rules
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			cs_prev_reg   <= aomc_pkg::PIN_IDLE[1];
			trig_prev_reg <= 1'b0;
		end else begin
			cs_prev_reg   <= cs_w;
			trig_prev_reg <= trig_w;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Mode state machine

	aomc_pkg::aomc_state_t state_reg, state_next;
	logic [aomc_pkg::CNT_W-1:0] cnt_reg, cnt_next;
	logic [aomc_pkg::ASLP_W-1:0] idle_cnt_reg, idle_cnt_next;
	logic act_auto_reg, act_auto_next;
	logic strap_next;
	logic meas_done_w;
	logic auto_en_w;
	logic act_eff_w;

	// Strap low enables auto sleep by count; strap high needs explicit enable
	// count enables
	assign auto_en_w = strap_reg ? (auto_sleep_en_i && auto_sleep_count_i != '0)
	                             : (auto_sleep_count_i != '0);
	assign act_eff_w = active_i || act_auto_reg;

	always_comb begin
		state_next    = state_reg;
		cnt_next      = cnt_reg;
		idle_cnt_next = idle_cnt_reg;
		act_auto_next = act_auto_reg;
		strap_next    = strap_reg;
		case (state_reg)
			aomc_pkg::ST_HIBERNATE: begin
				cnt_next = '0;
				if (!strap_w && cs_toggle_w) begin
					state_next = aomc_pkg::ST_BOOT;
					strap_next = 1'b0;
				end else if (strap_w && mot_w) begin
					state_next = aomc_pkg::ST_BOOT;
					strap_next = 1'b1;
				end
			end
			aomc_pkg::ST_BOOT: begin
				cnt_next = cnt_reg + 1'b1;
				if (!strap_reg && cnt_reg >= aomc_pkg::CNT_W'(BOOT_LOW_CYC - 1)) begin
					state_next = aomc_pkg::ST_STANDBY;
					cnt_next   = '0;
				end else if (strap_reg && cnt_reg >= aomc_pkg::CNT_W'(BOOT_HIGH_CYC - 1)) begin
					state_next    = aomc_pkg::ST_WAKE;
					act_auto_next = 1'b1;
					cnt_next      = '0;
				end
			end
			aomc_pkg::ST_STANDBY: begin
				idle_cnt_next = '0;
				if (!strap_reg && hibernate_en_i) begin
					state_next = aomc_pkg::ST_HIBERNATE;
				end else if (!strap_reg && second_pin_function_select_i) begin
					state_next = aomc_pkg::ST_TRIG_WAIT;
				end else if (act_eff_w) begin
					state_next = aomc_pkg::ST_WAKE;
				end
			end
			aomc_pkg::ST_WAKE, aomc_pkg::ST_SLEEP: begin
				if (!act_eff_w) begin
					state_next = aomc_pkg::ST_STANDBY;
				end else if (auto_en_w && activity_i) begin
					state_next    = aomc_pkg::ST_WAKE;
					idle_cnt_next = '0;
				end else if (auto_en_w && state_reg == aomc_pkg::ST_WAKE && meas_done_w) begin
					idle_cnt_next = idle_cnt_reg + 1'b1;
					if (idle_cnt_reg + 1'b1 >= auto_sleep_count_i) begin
						state_next = aomc_pkg::ST_SLEEP;
					end
				end else if (!auto_en_w) begin
					state_next = aomc_pkg::ST_WAKE;
				end
			end
			aomc_pkg::ST_TRIG_WAIT: begin
				if (!second_pin_function_select_i) begin
					state_next = aomc_pkg::ST_STANDBY;
				end else if (trig_rise_w) begin
					state_next = aomc_pkg::ST_TRIG_MEAS;
				end
			end
			aomc_pkg::ST_TRIG_MEAS: begin
				if (meas_done_w) begin
					state_next = aomc_pkg::ST_TRIG_WAIT;
				end
			end
			default: begin
				state_next = aomc_pkg::ST_HIBERNATE;
			end
		endcase
		if (strap_reg && state_reg != aomc_pkg::ST_HIBERNATE
		    && state_reg != aomc_pkg::ST_BOOT) begin
			if (mot_w) begin
				cnt_next = '0;
			end else if (cnt_reg >= aomc_pkg::CNT_W'(MOT_HOLD_CYC - 1)) begin
				state_next    = aomc_pkg::ST_HIBERNATE;
				act_auto_next = 1'b0;
				cnt_next      = '0;
			end else begin
				cnt_next = cnt_reg + 1'b1;
			end
		end
		if (state_next == aomc_pkg::ST_HIBERNATE) begin
			act_auto_next = 1'b0;
			idle_cnt_next = '0;
		end
		if (state_reg == aomc_pkg::ST_WAKE && state_next == aomc_pkg::ST_STANDBY) begin
			act_auto_next = 1'b0;
		end
	end

	// State registers
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			state_reg    <= aomc_pkg::ST_HIBERNATE;
			cnt_reg      <= '0;
			idle_cnt_reg <= '0;
			act_auto_reg <= 1'b0;
			strap_reg    <= 1'b0;
		end else begin
			state_reg    <= state_next;
			cnt_reg      <= cnt_next;
			idle_cnt_reg <= idle_cnt_next;
			act_auto_reg <= act_auto_next;
			strap_reg    <= strap_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Measurement pacing

	logic in_sleep_w, run_w, single_w, flex_w, hpm_w, analog_w, timer_clr_w;
	logic [aomc_pkg::ODR_W-1:0]  odr_w;
	logic [aomc_pkg::IDLE_W-1:0] idle_w;
	logic [aomc_pkg::DEC_W-1:0]  dec_w;

	assign in_sleep_w = state_reg == aomc_pkg::ST_SLEEP;
	assign odr_w      = in_sleep_w ? sleep_odr_i : wake_odr_i;
	assign flex_w     = in_sleep_w ? sleep_flex_en_i : wake_flex_en_i;
	assign idle_w     = in_sleep_w ? sleep_idle_i : wake_idle_i;
	assign dec_w      = in_sleep_w ? sleep_dec_i : wake_dec_i;
	assign hpm_w      = in_sleep_w ? sleep_hpm_i : wake_hpm_i;
	assign run_w      = state_reg == aomc_pkg::ST_WAKE || in_sleep_w;
	assign single_w   = state_reg == aomc_pkg::ST_TRIG_MEAS && !meas_done_w;
	// Stop pacing outside active states so standby and hibernate stay dark
	// analog off
	assign timer_clr_w = rst_i || !(run_w || single_w);

	aomc_meas_timer u_timer (
		.sys_clk_i   (sys_clk_i),
		.rst_i       (timer_clr_w),
		.run_i       (run_w),
		.single_i    (single_w),
		.odr_i       (odr_w),
		.flex_en_i   (flex_w),
		.idle_i      (idle_w),
		.dec_i       (dec_w),
		.analog_on_o (analog_w),
		.meas_done_o (meas_done_w)
	);

	////////////////////////////////////////////////////////////////////////////
	// Registered outputs

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			mode_o            <= aomc_pkg::ST_HIBERNATE;
			bus_avail_o       <= 1'b0;
			analog_on_o       <= 1'b0;
			high_perf_o       <= 1'b0;
			regs_default_o    <= 1'b0;
			regs_subset_rst_o <= 1'b0;
			active_set_o      <= 1'b0;
			boot_done_o       <= 1'b0;
			meas_done_o       <= 1'b0;
		end else begin
			mode_o            <= state_reg;
			bus_avail_o       <= state_reg != aomc_pkg::ST_HIBERNATE
			                     && state_reg != aomc_pkg::ST_BOOT;
			analog_on_o       <= analog_w;
			high_perf_o       <= hpm_w && run_w;
			regs_default_o    <= state_reg == aomc_pkg::ST_HIBERNATE
			                     || state_reg == aomc_pkg::ST_BOOT;
			regs_subset_rst_o <= state_reg == aomc_pkg::ST_STANDBY
			                     && state_next == aomc_pkg::ST_WAKE;
			active_set_o      <= act_auto_reg;
			boot_done_o       <= state_reg == aomc_pkg::ST_BOOT
			                     && state_next != aomc_pkg::ST_BOOT;
			meas_done_o       <= meas_done_w;
		end
	end

endmodule : aomc_mode_ctrl

// file: aomc_mode_ctrl_properties.sv
// Port checker for the operating mode controller.
`timescale 1ns/1ps
module aomc_mode_props #(
	parameter int unsigned BOOT_LOW_CYC  = 20,
	parameter int unsigned BOOT_HIGH_CYC = 20,
	parameter int unsigned MOT_HOLD_CYC  = 20
) (
	// Clock and reset
	input wire logic                        sys_clk_i,
	input wire logic                        rst_i,
	// Watched inputs
	input wire logic                        boot_strap_select_i,
	input wire logic                        motion_detect_pin_i,
	input wire logic                        hibernate_en_i,
	input wire logic                        auto_sleep_en_i,
	input wire logic [aomc_pkg::ASLP_W-1:0] auto_sleep_count_i,
	input wire logic                        wake_hpm_i,
	input wire logic                        sleep_hpm_i,
	// Watched outputs
	input wire logic [6:0]                  mode_o,
	input wire logic                        bus_avail_o,
	input wire logic                        analog_on_o,
	input wire logic                        high_perf_o,
	input wire logic                        regs_default_o,
	input wire logic                        regs_subset_rst_o,
	input wire logic                        boot_done_o
);
	logic [23:0] bcnt_reg;
	logic [23:0] mcnt_reg;
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);
	// Cycles shown in boot and cycles of a low motion pin
	always_ff @(posedge sys_clk_i) begin
		bcnt_reg <= (rst_i || mode_o != 7'h02) ? 24'h0 : bcnt_reg + 24'h1;
		mcnt_reg <= (rst_i || motion_detect_pin_i) ? 24'h0 : mcnt_reg + 24'h1;
	end
	hib_quiet_a: assert property (
		!$past(rst_i) && $past(mode_o) == 7'h01 && mode_o == 7'h01
		|-> !bus_avail_o && !analog_on_o && regs_default_o) else $error("hibernate not quiet");
	standby_off_a: assert property (
		$past(mode_o) == 7'h04 && mode_o == 7'h04 |-> bus_avail_o && !analog_on_o)
		else $error("standby power wrong");
	active_bus_a: assert property (
		(mode_o & 7'h78) != 7'h00 && $past(mode_o) == mode_o |-> bus_avail_o)
		else $error("bus lost while active");
	boot_len_a: assert property (
		$past(mode_o) == 7'h02 && mode_o != 7'h02 |-> bcnt_reg >= (boot_strap_select_i
		? BOOT_HIGH_CYC : BOOT_LOW_CYC) && mode_o == (boot_strap_select_i ? 7'h08 : 7'h04))
		else $error("boot length or exit wrong");
	boot_pulse_a: assert property (
		boot_done_o |-> ##[0:2] (mode_o == 7'h04 || mode_o == 7'h08)) else $error("stray boot pulse");
	trig_start_a: assert property (
		mode_o == 7'h40 && $past(mode_o) != 7'h40 |-> $past(mode_o) == 7'h20
		&& !boot_strap_select_i) else $error("measurement without trigger wait");
	trig_back_a: assert property (
		$fell(mode_o == 7'h40) |-> mode_o == 7'h20) else $error("no return to trigger wait");
	hib_entry_a: assert property (
		mode_o == 7'h01 && $past(mode_o) != 7'h01 |-> (boot_strap_select_i ? mcnt_reg >=
		MOT_HOLD_CYC : $past(mode_o) == 7'h04 && $past(hibernate_en_i)))
		else $error("hibernate entered early");
	sleep_entry_a: assert property (
		$rose(mode_o == 7'h10) |-> auto_sleep_count_i != 16'h0000
		&& (!boot_strap_select_i || auto_sleep_en_i)) else $error("sleep not enabled");
	keep_regs_a: assert property (
		mode_o == 7'h04 && $past(mode_o) == 7'h08 |-> !regs_subset_rst_o)
		else $error("registers reset on entering standby");
	subset_rst_a: assert property (
		regs_subset_rst_o |-> ##[0:2] mode_o == 7'h08) else $error("subset reset misplaced");
	hpm_select_a: assert property (
		$past(mode_o) == mode_o && (mode_o == 7'h08 || mode_o == 7'h10) && $stable(wake_hpm_i)
		&& $stable(sleep_hpm_i) |-> high_perf_o == (mode_o == 7'h08 ? wake_hpm_i : sleep_hpm_i))
		else $error("wrong performance setting");
endmodule : aomc_mode_props

bind aomc_mode_ctrl aomc_mode_props #(.BOOT_LOW_CYC(BOOT_LOW_CYC), .BOOT_HIGH_CYC(BOOT_HIGH_CYC),
	.MOT_HOLD_CYC(MOT_HOLD_CYC)) u_props (.sys_clk_i, .rst_i, .boot_strap_select_i,
	.motion_detect_pin_i, .hibernate_en_i, .auto_sleep_en_i, .auto_sleep_count_i, .wake_hpm_i,
	.sleep_hpm_i, .mode_o, .bus_avail_o, .analog_on_o, .high_perf_o, .regs_default_o,
	.regs_subset_rst_o, .boot_done_o);

// file: aomc_pkg.sv
// Package for the accelerometer operating mode controller: states, timings, settings.
package aomc_pkg;

	// Clock rate in kHz
	localparam int unsigned CLK_KHZ = 50000;

	// Boot intervals and motion-low hold time in microseconds
	localparam int unsigned BOOT_WAIT_LOW_US  = 1000;
	localparam int unsigned BOOT_WAIT_HIGH_US = 1000;
	localparam int unsigned MOT_LOW_HOLD_US   = 1000;

	// Cycle counts derived from the rate, least times round up
	localparam int unsigned BOOT_WAIT_LOW_CYC  = (BOOT_WAIT_LOW_US * CLK_KHZ + 999) / 1000;
	localparam int unsigned BOOT_WAIT_HIGH_CYC = (BOOT_WAIT_HIGH_US * CLK_KHZ + 999) / 1000;
	localparam int unsigned MOT_LOW_HOLD_CYC   = (MOT_LOW_HOLD_US * CLK_KHZ + 999) / 1000;

	// Idle levels of trigger, motion (pulled up), chip select (high) and strap pins
	localparam logic [3:0] PIN_IDLE = 4'h6;

	// Counter width for all long intervals
	localparam int unsigned CNT_W = 24;

	// Measurement and idle counters
	localparam int unsigned MEAS_CYC = 64;
	localparam int unsigned MEAS_W   = 8;
	localparam int unsigned IDLE_W   = 8;
	localparam int unsigned DEC_W    = 4;
	localparam int unsigned ODR_W    = 4;
	localparam int unsigned ASLP_W   = 16;

	// Operating modes, one-hot
	typedef enum logic [6:0] {
		ST_HIBERNATE = 7'h01,
		ST_BOOT      = 7'h02,
		ST_STANDBY   = 7'h04,
		ST_WAKE      = 7'h08,
		ST_SLEEP     = 7'h10,
		ST_TRIG_WAIT = 7'h20,
		ST_TRIG_MEAS = 7'h40
	} aomc_state_t;

endpackage : aomc_pkg
